// File: hw/adcc_top.sv
// converter control: start, trigger, completion flag, prescaler and result layout
`timescale 1ns/1ns
`default_nettype none
module adcc_top (
    // clock and reset
    input  wire logic       CORE_CLK_I,
    input  wire logic       NRST_I,
    // register port
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // processor side
    input  wire logic       GLOBAL_IRQ_EN_I,
    input  wire logic       VECTOR_ACK_I,
    output logic            CONV_IRQ_O,
    output logic            STATUS_IRQ_O,
    // trigger sources (from pins)
    input  wire logic [7:0] TRIG_SRC_I,
    // analog core
    output logic            SAMPLE_START_O,
    output logic            CONV_ACTIVE_O,
    input  wire logic [9:0] ANALOG_RESULT_I
);
    import adcc_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    typedef enum {ST_OFF, ST_IDLE, ST_CONV} adcc_state_t;
    adcc_state_t state;
    adcc_bus_t   bus;
    adcc_start_t req;

    logic       enable;
    logic       auto_en;
    logic       flag;
    logic       irq_en;
    logic [2:0] div_sel;
    logic [2:0] trig_sel;
    logic       left_adj;
    logic       free_run;
    logic       need_init;
    logic [4:0] cycles;
    logic [4:0] length;
    logic [9:0] result;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] trig_s1, trig_s2, trig_s3;
    logic       trig_prev;
    logic       trig_level;
    logic       trig_rise;
    logic       tick;
    logic       restart;
    logic       done;
    logic       wr_csr_a;
    logic       sw_start;

    assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign wr_csr_a = bus.wr && bus.addr == ADDR_CSR_A;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // place the 10-bit result into the low or high byte
    function automatic logic [7:0] res_byte(input logic [9:0] r, input logic left,
                                            input logic high);
        if (left) begin
            res_byte = high ? r[9:2] : {r[1:0], 6'h00};
        end else begin
            res_byte = high ? {6'h00, r[9:8]} : r[7:0];
        end
    endfunction

    // ---------------------------------------------------------------
    // trigger input synchroniser and edge detect
    // ---------------------------------------------------------------
    // three stage capture; change counts when stage two and three agree
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trig_s1 <= 8'h00;
            trig_s2 <= 8'h00;
            trig_s3 <= 8'h00;
        end else begin
            trig_s1 <= TRIG_SRC_I;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // selected source from the second control register
    assign trig_level = (trig_s2[trig_sel] == trig_s3[trig_sel]) ? trig_s3[trig_sel]
                                                                  : trig_prev;

    // last agreed level of the selected source
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_level;
        end
    end

    assign trig_rise = trig_level && !trig_prev;

    // ---------------------------------------------------------------
    // converter clock
    // ---------------------------------------------------------------
    // a start from idle realigns the divider so every conversion spans whole ticks
    assign restart = state != ST_CONV && (sw_start || enable && auto_en && trig_rise);

    adcc_prescaler u_prescaler (
        .clk_i  (CORE_CLK_I),
        .nrst_i (NRST_I),
        .run_i  (enable && !restart),
        .sel_i  (div_sel),
        .tick_o (tick)
    );

    // ---------------------------------------------------------------
    // start requests
    // ---------------------------------------------------------------
    // a start write of one counts only if the same write sets enable; zero is ignored
    assign sw_start = wr_csr_a && bus.wdata[BIT_START] && bus.wdata[BIT_ENABLE];

    // start request: software, auto trigger edge, or free running restart
    always_comb begin
        req.go    = 1'b0;
        req.first = need_init;
        if (sw_start) begin
            req.go = 1'b1;
        end else if (enable && auto_en && trig_rise) begin
            req.go = 1'b1;
        end else if (enable && free_run && done) begin
            req.go = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // control status a fields other than start and flag
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            enable  <= CSR_A_RESET[BIT_ENABLE];
            auto_en <= CSR_A_RESET[BIT_AUTO];
            irq_en  <= CSR_A_RESET[BIT_IRQ_EN];
            div_sel <= CSR_A_RESET[2:0];
        end else if (wr_csr_a) begin
            enable  <= bus.wdata[BIT_ENABLE];
            auto_en <= bus.wdata[BIT_AUTO];
            irq_en  <= bus.wdata[BIT_IRQ_EN];
            div_sel <= bus.wdata[2:0];
        end
    end

    // second control register and configuration
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trig_sel <= CSR_B_RESET[2:0];
            left_adj <= 1'b0;
            free_run <= 1'b0;
            irq_mask <= 2'h0;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_CSR_B) begin
                trig_sel <= bus.wdata[2:0];
            end
            if (bus.addr == ADDR_CFG) begin
                left_adj <= bus.wdata[BIT_LEFT_ADJ];
                free_run <= bus.wdata[BIT_FREE_RUN];
            end
            if (bus.addr == ADDR_IRQ_MASK) begin
                irq_mask <= bus.wdata[1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    assign done = state == ST_CONV && tick && cycles == 5'h01;

    // sequencer: counts converter ticks for 13 or 25 cycles
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state     <= ST_OFF;
            cycles    <= 5'h00;
            length    <= 5'h00;
            need_init <= 1'b1;
        end else if (wr_csr_a && !bus.wdata[BIT_ENABLE]) begin
            state     <= ST_OFF;
            cycles    <= 5'h00;
            need_init <= 1'b1;
        end else begin
            case (state)
                ST_OFF, ST_IDLE: begin
                    if (req.go) begin
                        state     <= ST_CONV;
                        length    <= req.first ? CONV_CYCLES_FIRST : CONV_CYCLES_NORMAL;
                        cycles    <= req.first ? CONV_CYCLES_FIRST : CONV_CYCLES_NORMAL;
                        need_init <= 1'b0;
                    end else if (wr_csr_a) begin
                        state <= ST_IDLE;
                    end
                end
                ST_CONV: begin
                    if (done && req.go) begin
                        cycles <= CONV_CYCLES_NORMAL;
                        length <= CONV_CYCLES_NORMAL;
                    end else if (done) begin
                        state  <= ST_IDLE;
                        cycles <= 5'h00;
                    end else if (tick) begin
                        cycles <= cycles - 5'h01;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    assign CONV_ACTIVE_O  = state == ST_CONV;
    assign SAMPLE_START_O = req.go && state != ST_CONV || done && req.go;

    // result capture on completion
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            result <= 10'h000;
        end else if (done) begin
            result <= ANALOG_RESULT_I;
        end
    end

    // completion flag: set wins over clears
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            flag <= CSR_A_RESET[BIT_FLAG];
        end else if (done) begin
            flag <= 1'b1;
        end else if (VECTOR_ACK_I) begin
            flag <= 1'b0;
        end else if (wr_csr_a && bus.wdata[BIT_FLAG]) begin
            flag <= 1'b0;
        end
    end

    assign CONV_IRQ_O = flag && irq_en && GLOBAL_IRQ_EN_I;

    // ---------------------------------------------------------------
    // sticky status interrupts
    // ---------------------------------------------------------------
    // completion and lost trigger events; read clears, event wins
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_stat <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (i == IRQ_DONE && done) begin
                    irq_stat[i] <= 1'b1;
                end else if (i == IRQ_TRIGLOST && state == ST_CONV && !done
                             && auto_en && trig_rise) begin
                    irq_stat[i] <= 1'b1;
                end else if (bus.rd && bus.addr == ADDR_IRQ_STAT) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end

    assign STATUS_IRQ_O = |(irq_stat & irq_mask);

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_CSR_A:    RDATA_O <= {enable, state == ST_CONV, auto_en, flag,
                                           irq_en, div_sel};
                ADDR_CSR_B:    RDATA_O <= {5'h00, trig_sel};
                ADDR_RES_LOW:  RDATA_O <= res_byte(result, left_adj, 1'b0);
                ADDR_RES_HIGH: RDATA_O <= res_byte(result, left_adj, 1'b1);
                ADDR_IRQ_STAT: RDATA_O <= {6'h00, irq_stat};
                ADDR_IRQ_MASK: RDATA_O <= {6'h00, irq_mask};
                ADDR_CFG:      RDATA_O <= {6'h00, free_run, left_adj};
                default:       RDATA_O <= 8'h00;
            endcase
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_sw_start;
        sw_start && state != ST_CONV;
    endsequence

    a_start_begins: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        s_sw_start |=> state == ST_CONV) else $error("start write did not begin conversion");
    a_zero_ignored: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (state == ST_CONV && wr_csr_a && bus.wdata[BIT_ENABLE] && !done)
        |=> state == ST_CONV) else $error("zero start write disturbed conversion");
    a_first_length: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (s_sw_start and need_init) |=> length == CONV_CYCLES_FIRST)
        else $error("first conversion not 25 cycles");
    a_normal_length: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (s_sw_start and !need_init) |=> length == CONV_CYCLES_NORMAL)
        else $error("normal conversion not 13 cycles");
    a_flag_on_done: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        done |=> flag && result == $past(ANALOG_RESULT_I)) else $error("flag or result missed");
    a_flag_write_clr: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_csr_a && bus.wdata[BIT_FLAG] && !done) |=> !flag) else $error("flag not cleared");
    a_vector_clear: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (VECTOR_ACK_I && !done) |=> !flag) else $error("vector did not clear flag");
    a_irq_gate: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        done ##1 (irq_en && GLOBAL_IRQ_EN_I) |-> CONV_IRQ_O)
        else $error("irq missing after completion");
    a_disable_abort: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_csr_a && !bus.wdata[BIT_ENABLE]) |=> state == ST_OFF && !CONV_ACTIVE_O)
        else $error("disable did not abort");
    a_free_run_next: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (done && enable && free_run && !wr_csr_a) |=> state == ST_CONV)
        else $error("free running did not restart");
    a_trig_starts: assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (state == ST_IDLE && enable && auto_en && trig_rise && !wr_csr_a) |=> state == ST_CONV)
        else $error("trigger edge did not start");
endmodule
`default_nettype wire

// File: hw/adcc_pkg.sv
// package: register map, field positions and timing counts for the converter control
package adcc_pkg;
    // register offsets (plain port, byte wide registers)
    localparam logic [2:0] ADDR_CSR_A     = 3'h0;
    localparam logic [2:0] ADDR_CSR_B     = 3'h1;
    localparam logic [2:0] ADDR_RES_LOW   = 3'h2;
    localparam logic [2:0] ADDR_RES_HIGH  = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STAT  = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK  = 3'h5;
    localparam logic [2:0] ADDR_CFG       = 3'h6;
    // control status a field positions
    localparam int BIT_ENABLE    = 7;
    localparam int BIT_START     = 6;
    localparam int BIT_AUTO      = 5;
    localparam int BIT_FLAG      = 4;
    localparam int BIT_IRQ_EN    = 3;
    // config register field positions
    localparam int BIT_LEFT_ADJ  = 0;
    localparam int BIT_FREE_RUN  = 1;
    // reset values
    localparam logic [7:0] CSR_A_RESET = 8'h00;
    localparam logic [7:0] CSR_B_RESET = 8'h00;
    // conversion lengths in converter clock cycles
    localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0d;
    localparam logic [4:0] CONV_CYCLES_FIRST  = 5'h19;
    // interrupt status bits
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_TRIGLOST = 1;
    // start request carrier
    typedef struct packed {
        logic       go;
        logic       first;
    } adcc_start_t;
    // register bus carrier
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcc_bus_t;
endpackage

// File: hw/adcc_prescaler.sv
// prescaler: converter clock enable from the system clock
`timescale 1ns/1ns
`default_nettype none
module adcc_prescaler (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // control
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    // converter clock enable
    output logic            tick_o
);
    import adcc_pkg::*;

    logic [6:0] count;
    logic [6:0] limit;

    // division factor minus one per code
    always_comb begin
        case (sel_i)
            3'h0, 3'h1: limit = 7'h01;
            3'h2:       limit = 7'h03;
            3'h3:       limit = 7'h07;
            3'h4:       limit = 7'h0f;
            3'h5:       limit = 7'h1f;
            3'h6:       limit = 7'h3f;
            default:    limit = 7'h7f;
        endcase
    end

    // counter held at zero while disabled
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= 7'h00;
        end else if (!run_i) begin
            count <= 7'h00;
        end else if (count >= limit) begin
            count <= 7'h00;
        end else begin
            count <= count + 7'h01;
        end
    end

    assign tick_o = run_i && (count >= limit);

    // a_tick_needs_run: no converter tick while disabled
    a_tick_needs_run: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !run_i |-> !tick_o) else $error("prescaler tick while disabled");
    // a_div2_period: code 1 gives a tick every two cycles
    a_div2_period: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_o && run_i && sel_i == 3'h1 && $stable(sel_i)) ##1 (run_i && sel_i == 3'h1)
        |=> tick_o || !run_i) else $error("divide by two period wrong");
endmodule
`default_nettype wire

// File: verification/adcc_analog_model.sv
// analog core model: new sample per conversion, scrambled output when idle
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // conversion control from the block
    input  wire logic       start_i,
    input  wire logic       active_i,
    // result toward the block, value for the bench
    output logic      [9:0] result_o,
    output logic      [9:0] value_o
);
    logic [9:0] flip;
    // a fresh value for every started conversion
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            value_o <= 10'h2a6;
        end else if (start_i) begin
            value_o <= value_o + 10'h0d3;
        end
    end
    // toggling pattern so idle output alternates between inverted and true value
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flip <= 10'h000;
        end else begin
            flip <= ~flip;
        end
    end
    // result only holds still while a conversion runs
    assign result_o = active_i ? value_o : (~value_o ^ flip);
endmodule
`default_nettype wire

// File: verification/adc_conversion_control_tb.sv
// testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_control_tb;
    import adcc_pkg::*;
    typedef struct packed {logic [2:0] code; int first; int normal;} adcc_row_t;
    logic clk, nrst, wr, rd, gie, vack, irq, sirq, start, active;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, trig, d;
    logic [9:0] res, val;
    int n_errors, num_checks;
    adcc_row_t rows [8];
    // device under test and analog core
    adcc_top uut (.CORE_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GLOBAL_IRQ_EN_I(gie), .VECTOR_ACK_I(vack),
        .CONV_IRQ_O(irq), .STATUS_IRQ_O(sirq), .TRIG_SRC_I(trig),
        .SAMPLE_START_O(start), .CONV_ACTIVE_O(active), .ANALOG_RESULT_I(res));
    adcc_analog_model core (.clk_i(clk), .nrst_i(nrst), .start_i(start),
        .active_i(active), .result_o(res), .value_o(val));
    // 25 MHz clock
    always #20 clk = ~clk;
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic wait_for(input logic lvl, input int bound);
        int k;
        k = 0;
        while (active !== lvl && k < bound) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (active !== lvl) begin
            n_errors++;
            $display("unexpected at %0t: wait ran out", $time);
            close_out();
        end
    endtask
    // length of one conversion in system clocks, two cycles of slack
    task automatic measure(input int exp);
        int n;
        wait_for(1'b1, 200);
        n = 0;
        while (active === 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        num_checks++;
        if (n < exp - 2 || n > exp + 2) begin
            n_errors++;
            $display("unexpected at %0t: length %0d want %0d", $time, n, exp);
        end
    endtask
    initial begin
        clk = 0; nrst = 0; addr = 0; wdata = 0; wr = 0; rd = 0;
        gie = 0; vack = 0; trig = 8'h00; n_errors = 0; num_checks = 0;
        for (int i = 0; i < 8; i++) begin
            rows[i].code   = 3'(i);
            rows[i].first  = 25 * (i < 2 ? 2 : (1 << i));
            rows[i].normal = 13 * (i < 2 ? 2 : (1 << i));
        end
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        // reset values and an unmapped address
        rd_chk(ADDR_CSR_A, CSR_A_RESET);
        rd_chk(ADDR_CSR_B, CSR_B_RESET);
        rd_chk(3'h7, 8'h00);
        // every divider code: first and normal conversion, flag, result layout
        for (int i = 0; i < 8; i++) begin
            wr_reg(ADDR_CSR_A, 8'h00);
            wr_reg(ADDR_CSR_A, {5'h18, rows[i].code});
            measure(rows[i].first);
            rd_chk(ADDR_CSR_A, {5'h12, rows[i].code});
            rd_chk(ADDR_RES_HIGH, {6'h00, val[9:8]});
            rd_chk(ADDR_RES_LOW, val[7:0]);
            wr_reg(ADDR_CSR_A, {5'h12, rows[i].code});
            rd_chk(ADDR_CSR_A, {5'h10, rows[i].code});
            wr_reg(ADDR_CSR_A, {5'h18, rows[i].code});
            measure(rows[i].normal);
            wr_reg(ADDR_CSR_A, {5'h10, rows[i].code});
            rd_chk(ADDR_CSR_A, {5'h12, rows[i].code});
        end
        // auto trigger: unselected source ignored, selected rising edge starts
        wr_reg(ADDR_CSR_A, 8'h90);
        rd_chk(ADDR_IRQ_STAT, 8'h01);
        wr_reg(ADDR_CSR_B, 8'h02);
        wr_reg(ADDR_CSR_A, 8'ha8);
        gie <= 1'b1;
        @(posedge clk);
        trig <= 8'h20;
        repeat (10) @(posedge clk);
        #1;
        check({7'h00, active}, 8'h00);
        @(posedge clk);
        trig <= 8'h24;
        wait_for(1'b1, 8);
        @(posedge clk);
        trig <= 8'h20;
        repeat (3) @(posedge clk);
        trig <= 8'h24;
        wait_for(1'b0, 40);
        repeat (8) @(posedge clk);
        #1;
        check({7'h00, active}, 8'h00);
        // completion interrupt gating and vector clear
        check({7'h00, irq}, 8'h01);
        @(posedge clk);
        gie <= 1'b0;
        #1;
        check({7'h00, irq}, 8'h00);
        @(posedge clk);
        gie  <= 1'b1;
        vack <= 1'b1;
        @(posedge clk);
        vack <= 1'b0;
        #1;
        check({7'h00, irq}, 8'h00);
        rd_chk(ADDR_CSR_A, 8'ha8);
        // status interrupt: mask decides, read clears
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        #1;
        d[0] = sirq;
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        #1;
        check({7'h00, d[0] ^ sirq}, 8'h01);
        wr_reg(ADDR_IRQ_MASK, 8'h03);
        #1;
        check({7'h00, sirq}, 8'h01);
        rd_chk(ADDR_IRQ_STAT, 8'h03);
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        check({7'h00, sirq}, 8'h00);
        // writing zero to start does not abort, disabling does
        wr_reg(ADDR_CSR_A, 8'h80);
        wr_reg(ADDR_CSR_A, 8'hc0);
        wait_for(1'b1, 4);
        wr_reg(ADDR_CSR_A, 8'h80);
        rd_chk(ADDR_CSR_A, 8'hc0);
        wr_reg(ADDR_CSR_A, 8'h00);
        @(posedge clk);
        #1;
        check({7'h00, active}, 8'h00);
        repeat (60) @(posedge clk);
        rd_chk(ADDR_CSR_A, 8'h00);
        // free running restarts by itself, then left adjust applies at once
        wr_reg(ADDR_CFG, 8'h02);
        wr_reg(ADDR_CSR_A, 8'hc0);
        wait_for(1'b1, 4);
        // first conversion ends after 25 ticks of two cycles, the next starts at once
        repeat (47) @(posedge clk);
        #1;
        check({7'h00, start}, 8'h00);
        @(posedge clk);
        #1;
        check({7'h00, start}, 8'h01);
        check({7'h00, active}, 8'h01);
        wr_reg(ADDR_CFG, 8'h01);
        wait_for(1'b0, 40);
        repeat (4) @(posedge clk);
        #1;
        check({7'h00, active}, 8'h00);
        rd_chk(ADDR_RES_HIGH, val[9:2]);
        rd_chk(ADDR_RES_LOW, {val[1:0], 6'h00});
        wr_reg(ADDR_CFG, 8'h00);
        rd_chk(ADDR_RES_HIGH, {6'h00, val[9:8]});
        close_out();
    end
endmodule
`default_nettype wire
